//--- pkg/fslb_pkg.sv
// Purpose: constants for the fault status latch bank
// Assumes: 8-bit register addresses and 8-bit register data
// Notes:   fault level masks give, per bit, the level that counts as a fault
package fslb_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] LIVE_PIN_STATUS_OFS        = 8'h02;
  localparam logic [7:0] MONITOR_FAULT_LATCH_OFS    = 8'h2a;
  localparam logic [7:0] SUPPLY_INTEGRITY_LATCH_OFS = 8'h2b;
  localparam logic [7:0] PIN_EVENT_LATCH_OFS        = 8'h2c;

  // ****************************************************************
  // live status field positions
  // ****************************************************************
  localparam int LIVE_FAULT_BIT    = 0;
  localparam int LIVE_PULSE_BIT    = 1;
  localparam int LIVE_OCP_BIT      = 2;
  localparam int LIVE_OUT_GOOD_BIT = 3;
  localparam int LIVE_LINK_BIT     = 4;
  localparam int LIVE_ENABLE_BIT   = 5;
  localparam int LIVE_REQ_BIT      = 6;
  localparam int LIVE_MAINS_BIT    = 7;

  // ****************************************************************
  // reset values and fault levels
  // ****************************************************************
  localparam logic [7:0] REG_RESET_VAL   = 8'h00;
  localparam logic       BIT_RESET_VAL   = 1'b0;
  // monitor bank: every flag is a fault when high
  localparam logic [7:0] MON_FAULT_LVL   = 8'hff;
  // integrity bank: supply overvoltage high, every ok flag low
  localparam logic [7:0] SUP_FAULT_LVL   = 8'h01;
  // pin bank: summary fault and overcurrent high, the rest low
  localparam logic [7:0] PIN_FAULT_LVL   = 8'h05;

endpackage : fslb_pkg

//--- rtl/fslb_top.sv
// Purpose: live pin status and sticky fault latch registers
// Assumes: all flag inputs synchronous to ref_clk_i; read port driven by
//          the serial management port logic
// Notes:   latch registers clear on read; a fault present in the read
//          cycle survives the clear
//          summary fault clears only through fault_clear_i; set wins
//          no write path exists, so a read is the only latch clear
// Overview of operation
// - live status bit 4 shows power-on link pin level, unlatched.
// - live status bit 5 shows power enable pin level.
// - live status bit 6 shows power-on request pin level.
// - live status bit 7 shows mains-sense pin level.
// - monitor latch holds monitor five..one, ocp timeout, uv, ov faults.
// - integrity latch holds supply ov and seven ok-flag faults.
// - pin latch holds summary fault, pulse, overcurrent, five pin states.
// - live bit 0 sets on overvoltage, undervoltage or overcurrent timeout.
// - flags named ok are active high; low level means fault.
`timescale 1ns/10ps
module fslb_top (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // read port
  input  wire logic       rd_en_i,
  input  wire logic [7:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  output logic            rd_hit_o,
  // summary fault clear
  input  wire logic       fault_clear_i,
  // monitor flags
  input  wire logic       monitor_input_one_i,
  input  wire logic       monitor_input_two_i,
  input  wire logic       monitor_input_three_i,
  input  wire logic       monitor_input_four_i,
  input  wire logic       monitor_input_five_i,
  input  wire logic       ocp_timeout_i,
  input  wire logic       uv_fault_i,
  input  wire logic       ov_fault_i,
  // supply integrity flags
  input  wire logic       supply_ov_i,
  input  wire logic       ext_ref_ok_i,
  input  wire logic       int_ref_ok_i,
  input  wire logic       ground_ok_i,
  input  wire logic       supply_ok_i,
  input  wire logic       reverse_ok_i,
  input  wire logic       out_switch_ok_i,
  input  wire logic       share_ok_i,
  // pin and detector states
  input  wire logic       pulse_ok_i,
  input  wire logic       ocp_flag_i,
  input  wire logic       output_good_pin_i,
  input  wire logic       power_on_link_i,
  input  wire logic       power_enable_input_i,
  input  wire logic       power_on_request_i,
  input  wire logic       mains_sense_i
);
  import fslb_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one where the flag sits at its fault level
  function automatic logic [7:0] fault_hits(input logic [7:0] flags,
                                            input logic [7:0] lvl);
    fault_hits = ~(flags ^ lvl);
  endfunction

  logic [7:0] live_r;
  logic [7:0] live_nxt;
  logic       fault_r;
  logic       fault_nxt;
  logic [7:0] mon_latch_r;
  logic [7:0] mon_latch_nxt;
  logic [7:0] sup_latch_r;
  logic [7:0] sup_latch_nxt;
  logic [7:0] pin_latch_r;
  logic [7:0] pin_latch_nxt;
  logic [7:0] mon_flags;
  logic [7:0] sup_flags;
  logic [7:0] pin_flags;
  logic       clr_mon;
  logic       clr_sup;
  logic       clr_pin;
  logic [7:0] rd_data_nxt;
  logic       rd_hit_nxt;

  // ****************************************************************
  // flag vectors in register bit order
  // ****************************************************************
  // ok flags keep pin polarity; the fault level masks invert them
  assign mon_flags = {ov_fault_i, uv_fault_i, ocp_timeout_i,
                      monitor_input_one_i, monitor_input_two_i,
                      monitor_input_three_i, monitor_input_four_i,
                      monitor_input_five_i};
  assign sup_flags = {share_ok_i, out_switch_ok_i, reverse_ok_i,
                      supply_ok_i, ground_ok_i, int_ref_ok_i,
                      ext_ref_ok_i, supply_ov_i};
  assign pin_flags = {mains_sense_i, power_on_request_i,
                      power_enable_input_i, power_on_link_i,
                      output_good_pin_i, ocp_flag_i, pulse_ok_i,
                      fault_r};

  // ****************************************************************
  // summary fault, sticky
  // ****************************************************************
  // set beats clear so a fault in the clear cycle is kept
  assign fault_nxt = (fault_r & ~fault_clear_i)
                   | ov_fault_i | uv_fault_i | ocp_timeout_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r <= BIT_RESET_VAL;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // ****************************************************************
  // live status register
  // ****************************************************************
  // one cycle of sampling delay, no holding
  // bit 0 shows the summary fault one edge ahead of its latch copy
  always_comb begin
    live_nxt                    = REG_RESET_VAL;
    live_nxt[LIVE_FAULT_BIT]    = fault_nxt;
    live_nxt[LIVE_PULSE_BIT]    = pulse_ok_i;
    live_nxt[LIVE_OCP_BIT]      = ocp_flag_i;
    live_nxt[LIVE_OUT_GOOD_BIT] = output_good_pin_i;
    live_nxt[LIVE_LINK_BIT]     = power_on_link_i;
    live_nxt[LIVE_ENABLE_BIT]   = power_enable_input_i;
    live_nxt[LIVE_REQ_BIT]      = power_on_request_i;
    live_nxt[LIVE_MAINS_BIT]    = mains_sense_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live_r <= REG_RESET_VAL;
    end else begin
      live_r <= live_nxt;
    end
  end

  // ****************************************************************
  // sticky latches, clear on read
  // ****************************************************************
  // any read of a latch address clears it, back to back reads too
  assign clr_mon = rd_en_i && (rd_addr_i == MONITOR_FAULT_LATCH_OFS);
  assign clr_sup = rd_en_i && (rd_addr_i == SUPPLY_INTEGRITY_LATCH_OFS);
  assign clr_pin = rd_en_i && (rd_addr_i == PIN_EVENT_LATCH_OFS);

  // fault in the read cycle wins over the clear
  assign mon_latch_nxt = (clr_mon ? REG_RESET_VAL : mon_latch_r)
                       | fault_hits(mon_flags, MON_FAULT_LVL);
  assign sup_latch_nxt = (clr_sup ? REG_RESET_VAL : sup_latch_r)
                       | fault_hits(sup_flags, SUP_FAULT_LVL);
  assign pin_latch_nxt = (clr_pin ? REG_RESET_VAL : pin_latch_r)
                       | fault_hits(pin_flags, PIN_FAULT_LVL);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mon_latch_r <= REG_RESET_VAL;
    end else begin
      mon_latch_r <= mon_latch_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sup_latch_r <= REG_RESET_VAL;
    end else begin
      sup_latch_r <= sup_latch_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_latch_r <= REG_RESET_VAL;
    end else begin
      pin_latch_r <= pin_latch_nxt;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // data returned is the value before the clear
  always_comb begin
    rd_data_nxt = REG_RESET_VAL;
    rd_hit_nxt  = 1'b1;
    unique case (rd_addr_i)
      LIVE_PIN_STATUS_OFS:        rd_data_nxt = live_r;
      MONITOR_FAULT_LATCH_OFS:    rd_data_nxt = mon_latch_r;
      SUPPLY_INTEGRITY_LATCH_OFS: rd_data_nxt = sup_latch_r;
      PIN_EVENT_LATCH_OFS:        rd_data_nxt = pin_latch_r;
      default:                    rd_hit_nxt  = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      // valid answers every request, mapped or not
      rd_valid_o <= rd_en_i;
    end
  end

  // data and hit hold their value between reads
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= REG_RESET_VAL;
      rd_hit_o   <= 1'b0;
    end else begin
      if (rd_en_i) begin
        rd_data_o <= rd_data_nxt;
        rd_hit_o  <= rd_hit_nxt;
      end
    end
  end

endmodule // fslb_top

//--- verif/fslb_props.sv
// Purpose: port assertions for fslb_top
// Assumes: pins steady across live status reads
// Notes:   bound to every fslb_top
`timescale 1ns/10ps
module fslb_props (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       rd_en_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       rd_valid_o,
  input wire logic       rd_hit_o,
  input wire logic       ov_fault_i,
  input wire logic       power_on_link_i,
  input wire logic       power_enable_input_i,
  input wire logic       power_on_request_i,
  input wire logic       mains_sense_i
);
  // ********
  // read port
  // ********
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic lv;
  assign lv = rd_en_i && rd_addr_i == 8'h02;
  property p_ans; rd_en_i |=> rd_valid_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_idle; !rd_en_i |=> !rd_valid_o && $stable(rd_data_o);
  endproperty
  a_idle: assert property (p_idle) else $error("idle read port moved");
  property p_miss; rd_en_i && rd_addr_i == 8'h01 |=> !rd_hit_o
    && rd_data_o == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped answered");
  // stable pin guard: holds for either live latency
  property p_link; lv && $stable(power_on_link_i)
    |=> rd_data_o[4] == $past(power_on_link_i); endproperty
  a_link: assert property (p_link) else $error("bit 4 wrong");
  property p_enable; lv && $stable(power_enable_input_i)
    |=> rd_data_o[5] == $past(power_enable_input_i); endproperty
  a_enable: assert property (p_enable) else $error("bit 5 wrong");
  property p_req; lv && $stable(power_on_request_i)
    |=> rd_data_o[6] == $past(power_on_request_i); endproperty
  a_req: assert property (p_req) else $error("bit 6 wrong");
  property p_mains; lv && $stable(mains_sense_i)
    |=> rd_data_o[7] == $past(mains_sense_i); endproperty
  a_mains: assert property (p_mains) else $error("bit 7 wrong");
  // the live copy read out lags the fault input by one edge
  property p_fault; lv && $past(ov_fault_i) |=> rd_data_o[0]; endproperty
  a_fault: assert property (p_fault) else $error("fault missed");
  c_live: cover property (lv);
  c_mon: cover property (rd_en_i && rd_addr_i == 8'h2a);
  c_pin: cover property (rd_en_i && rd_addr_i == 8'h2c);
endmodule // fslb_props
bind fslb_top fslb_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .rd_hit_o(rd_hit_o), .ov_fault_i(ov_fault_i),
  .power_on_link_i(power_on_link_i), .mains_sense_i(mains_sense_i),
  .power_enable_input_i(power_enable_input_i),
  .power_on_request_i(power_on_request_i));

//--- verif/tb.sv
// Purpose: self-checking bench for fslb_top
// Assumes: clear-on-read latches
// Notes:   read results checked in order from a queue
`timescale 1ns/10ps
module tb;
  // ********
  // stimulus and checking
  // ********
  logic       ref_clk_i, rst_n_i, rd_en_i, fault_clear_i, rd_valid_o, rd_hit_o;
  logic [7:0] rd_addr_i, rd_data_o, mon, sup;
  logic [7:1] pn;
  logic [8:0] q[$];
  logic [3:0] r;
  integer     seed, mismatches, num_checks, cyc, i;
  fslb_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .rd_hit_o(rd_hit_o), .fault_clear_i(fault_clear_i),
    .monitor_input_five_i(mon[0]), .monitor_input_four_i(mon[1]),
    .monitor_input_three_i(mon[2]), .monitor_input_two_i(mon[3]),
    .monitor_input_one_i(mon[4]), .ocp_timeout_i(mon[5]),
    .uv_fault_i(mon[6]), .ov_fault_i(mon[7]), .supply_ov_i(sup[0]),
    .ext_ref_ok_i(sup[1]), .int_ref_ok_i(sup[2]), .ground_ok_i(sup[3]),
    .supply_ok_i(sup[4]), .reverse_ok_i(sup[5]), .out_switch_ok_i(sup[6]),
    .share_ok_i(sup[7]), .pulse_ok_i(pn[1]), .ocp_flag_i(pn[2]),
    .output_good_pin_i(pn[3]), .power_on_link_i(pn[4]),
    .power_enable_input_i(pn[5]), .power_on_request_i(pn[6]),
    .mains_sense_i(pn[7]));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] hit_data exp %h seen %h", e, s);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  // one read: request held one cycle, expectation noted
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic h = 1'b1);
    tick();
    rd_en_i = 1'b1;
    rd_addr_i = a;
    q.push_back({h, e});
    tick();
    rd_en_i = 1'b0;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // negedge sampling keeps clear of the launching edge
  always @(negedge ref_clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      test_done();
    end else if (rd_valid_o === 1'b1) begin
      chk({rd_hit_o, rd_data_o}, q.pop_front());
    end
  end
  initial begin
    seed = 32'hf944_1f61;
    mismatches = 0;
    num_checks = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    rd_en_i = 1'b0;
    rd_addr_i = 8'h00;
    fault_clear_i = 1'b0;
    mon = 8'h00;
    sup = 8'hfe;
    pn = 7'h7d;
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    rd(8'h2a, 8'h00); rd(8'h2b, 8'h00); rd(8'h2c, 8'h00);
    rd(8'h01, 8'h00, 1'b0); rd(8'h2d, 8'h00, 1'b0);
    for (i = 0; i < 8; i++) begin
      tick(); mon[i] = 1'b1; sup[i] = ~sup[i];
      tick(); mon = 8'h00; sup = 8'hfe;
      rd(8'h2a, 8'(1 << i));
      rd(8'h2b, 8'(1 << i));
      rd(8'h2a, 8'h00);
    end
    rd(8'h02, 8'hfb);
    tick(); fault_clear_i = 1'b1;
    tick(); fault_clear_i = 1'b0;
    rd(8'h02, 8'hfa); rd(8'h2c, 8'h01); rd(8'h2c, 8'h00);
    // fault and clear in one cycle: the set must win
    tick();
    mon = 8'h81;
    fault_clear_i = 1'b1;
    rd(8'h02, 8'hfb);
    rd(8'h2a, 8'h81);
    mon = 8'h00;
    tick();
    fault_clear_i = 1'b0;
    rd(8'h02, 8'hfa);
    rd(8'h2a, 8'h81);
    rd(8'h2a, 8'h00);
    rd(8'h2c, 8'h01);
    for (i = 1; i < 8; i++) begin
      tick(); pn[i] = ~pn[i];
      tick(); pn = 7'h7d;
      rd(8'h2c, 8'(1 << i));
    end
    for (i = 0; i < 6; i++) begin
      r = 4'($random(seed));
      tick(); pn[7:4] = r;
      tick(); tick();
      rd(8'h02, {r, 4'ha});
      pn = 7'h7d;
      tick(); tick();
      rd(8'h2c, {~r, 4'h0});
    end
    repeat (3) tick();
    test_done();
  end
endmodule // tb
